/* File: hw/rltm_device.sv */
// device end: relink, auto-transfer and test mode control
//
// Contract
// - rx transfer status skips receiver mode register
// - reconfigure whenever a link is established
// - link mode bit 4 forces relink
// - listed settings change only at reconfiguration
// - only eeprom load disables receiver slave
// - hop table loaded locally on each side
// - transmitter sends sampling rate while locating
// - transmitter sends receiver mode while locating
// - receiver sends input pins locating and streaming
// - remote execute transfer register to receiver masters
// - test registers then force bit enter test
// - test mode left and changed only by reset
// - test registers reachable through slave interface
// - eeprom bit6 removes slave; low data aborts
// - codes 0x63 single, 0x73 sweep
// - channel bit7 tx/rx, bits 6:0 offset
// - test mode forces 0 dBm output power
// - transfer status: 1 busy, 0 ok, 2 failed
//
// Our own choice: register access over AXI4-Lite.
`include "rltm_defines.svh"
module rltm_device #(
   parameter bit RECEIVER = 1'b0
) (
   input wire logic MCLK,
   input wire logic NRST,
   rltm_if.dev BUS,
   input wire logic LINK_LOCATE,
   input wire logic LINK_UP,
   input wire logic [3:0] XFER_DONE,
   input wire logic [3:0] XFER_FAIL,
   input wire logic EE_LOAD_DONE,
   input wire logic EE_SLAVE_OFF,
   input wire logic EE_DATA,
   output logic RECONFIG,
   output logic [3:0] RATE_ACTIVE,
   output logic RX_MODE_B2,
   output logic [5:0] OUT_PORT_ACTIVE,
   output logic [3:0] XFER_BUSY,
   output logic SEND_AUTO_CFG,
   output logic SEND_PINS,
   output logic SLAVE_EN,
   output logic TEST_ACTIVE,
   output logic TEST_SWEEP,
   output logic TEST_TX,
   output logic [6:0] TEST_CHAN,
   output logic [1:0] TX_POWER
);
   rltm_pkg::rltm_dev_t q;
   rltm_pkg::rltm_dev_t next_q;
   logic ee_data_sync;

   if (RECEIVER !== 1'b0 && RECEIVER !== 1'b1) begin : g_chk
      $error("RECEIVER must be 0 or 1");
   end

   rltm_sync #(.WIDTH(1)) u_ee_sync (
      .MCLK(MCLK),
      .NRST(NRST),
      .D(EE_DATA),
      .Q(ee_data_sync)
   );

   // transfer channel index of an offset, 4 when none
   function automatic logic [2:0] xfer_index(input logic [6:0] a);
      case (a)
         `RLTM_OFS_TX_CFG: xfer_index = 3'd0;
         `RLTM_OFS_LINK_CFG: xfer_index = 3'd1;
         `RLTM_OFS_RX_CFG: xfer_index = 3'd2;
         `RLTM_OFS_EXEC_CFG: xfer_index = 3'd3;
         default: xfer_index = 3'd4;
      endcase
   endfunction

   function automatic logic is_test_code(input logic [7:0] c);
      is_test_code = (c == `RLTM_CODE_SINGLE) || (c == `RLTM_CODE_SWEEP);
   endfunction

   function automatic logic [7:0] read_reg(input rltm_pkg::rltm_dev_t s, input logic [6:0] a);
      logic [2:0] x;
      x = xfer_index(a);
      read_reg = 8'h00;
      if (x != 3'd4) begin
         read_reg = {6'h00, s.fail[x[1:0]], s.busy[x[1:0]]};
      end else begin
         case (a)
            `RLTM_OFS_LINK_MODE: read_reg = s.link_mode;
            `RLTM_OFS_TX_STATUS: read_reg = s.tx_status_pend;
            `RLTM_OFS_RX_MODE: read_reg = s.rx_mode;
            `RLTM_OFS_OUT_PORT: read_reg = s.out_port_pend;
            `RLTM_OFS_POWER: read_reg = {6'h00, s.power};
            `RLTM_OFS_RX_STATUS: read_reg = {1'b0, s.slave_off, 6'h00};
            default: read_reg = 8'h00;
         endcase
      end
   endfunction

   always_comb begin
      logic force_relink;
      logic [2:0] x;
      force_relink = 1'b0;
      x = xfer_index(BUS.addr);
      next_q = q;
      next_q.ack = 1'b0;
      next_q.link_up_d = LINK_UP;
      // link engine outcomes; a start write is only taken when idle
      for (int i = 0; i < 4; i++) begin
         if (XFER_DONE[i]) begin
            next_q.busy[i] = 1'b0;
            next_q.fail[i] = 1'b0;
         end else if (XFER_FAIL[i]) begin
            next_q.busy[i] = 1'b0;
            next_q.fail[i] = 1'b1;
         end
      end
      if (BUS.req && !q.ack) begin
         next_q.ack = 1'b1;
         // no slave interface: reads give zero, writes are dropped
         next_q.rdata = q.slave_off ? 8'h00 : read_reg(q, BUS.addr);
         if (BUS.we && !q.slave_off) begin
            if (x != 3'd4) begin
               if (BUS.wdata == `RLTM_XFER_START && !q.busy[x[1:0]]) begin
                  next_q.busy[x[1:0]] = 1'b1;
                  next_q.fail[x[1:0]] = 1'b0;
               end
            end else begin
               case (BUS.addr)
                  `RLTM_OFS_LINK_MODE: begin
                     next_q.link_mode = BUS.wdata;
                     next_q.link_mode[`RLTM_FORCE_BIT] = 1'b0;
                     force_relink = BUS.wdata[`RLTM_FORCE_BIT];
                  end
                  `RLTM_OFS_TX_STATUS: begin
                     if (!q.busy[0]) begin
                        next_q.tx_status_pend = BUS.wdata;
                     end
                  end
                  `RLTM_OFS_RX_MODE: next_q.rx_mode = BUS.wdata;
                  `RLTM_OFS_OUT_PORT: begin
                     if (!q.busy[2]) begin
                        next_q.out_port_pend = BUS.wdata;
                     end
                  end
                  `RLTM_OFS_POWER: next_q.power = BUS.wdata[1:0];
                  `RLTM_OFS_TEST_MODE: begin
                     if (!q.test_on) begin
                        next_q.test_code_pend = BUS.wdata;
                     end
                  end
                  `RLTM_OFS_TEST_CHAN: begin
                     if (!q.test_on) begin
                        next_q.test_chan_pend = BUS.wdata;
                     end
                  end
                  default: next_q.rdata = next_q.rdata;
               endcase
            end
         end
      end
      next_q.reconfig = force_relink || (LINK_UP && !q.link_up_d);
      if (next_q.reconfig) begin
         next_q.rate_active = q.tx_status_pend[6:3];
         next_q.rx_mode_b2 = q.rx_mode[2];
         next_q.out_port_active = q.out_port_pend[5:0];
      end
      if (force_relink && !q.test_on && is_test_code(q.test_code_pend)) begin
         next_q.test_on = 1'b1;
         next_q.test_sweep = (q.test_code_pend == `RLTM_CODE_SWEEP);
         next_q.test_tx = q.test_chan_pend[`RLTM_TEST_TX_BIT];
         next_q.test_chan = q.test_chan_pend[6:0];
      end
      next_q.tx_power = next_q.test_on ? `RLTM_PWR_0DBM : next_q.power;
      // sampling rate and receiver mode ride the locate exchange
      next_q.send_auto = !RECEIVER && LINK_LOCATE && !next_q.test_on;
      next_q.send_pins = RECEIVER && (LINK_LOCATE || LINK_UP) && !next_q.test_on;
      if (RECEIVER && EE_LOAD_DONE && EE_SLAVE_OFF && ee_data_sync) begin
         next_q.slave_off = 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign BUS.ack = q.ack;
   assign BUS.rdata = q.rdata;
   assign RECONFIG = q.reconfig;
   assign RATE_ACTIVE = q.rate_active;
   assign RX_MODE_B2 = q.rx_mode_b2;
   assign OUT_PORT_ACTIVE = q.out_port_active;
   assign XFER_BUSY = q.busy;
   assign SEND_AUTO_CFG = q.send_auto;
   assign SEND_PINS = q.send_pins;
   assign SLAVE_EN = !q.slave_off;
   assign TEST_ACTIVE = q.test_on;
   assign TEST_SWEEP = q.test_sweep;
   assign TEST_TX = q.test_tx;
   assign TEST_CHAN = q.test_chan;
   assign TX_POWER = q.tx_power;
endmodule

/* File: hw/rltm_defines.svh */
// offsets, field positions, codes and reset values of the relink/test control
`ifndef RLTM_DEFINES_SVH
`define RLTM_DEFINES_SVH
`define RLTM_OFS_RX_MODE 7'h41
`define RLTM_OFS_TX_STATUS 7'h42
`define RLTM_OFS_OUT_PORT 7'h43
`define RLTM_OFS_POWER 7'h44
`define RLTM_OFS_RX_STATUS 7'h45
`define RLTM_OFS_EXEC_CFG 7'h47
`define RLTM_OFS_LINK_MODE 7'h50
`define RLTM_OFS_TX_CFG 7'h5B
`define RLTM_OFS_LINK_CFG 7'h3E
`define RLTM_OFS_RX_CFG 7'h4B
`define RLTM_OFS_TEST_MODE 7'h7E
`define RLTM_OFS_TEST_CHAN 7'h7F
`define RLTM_FORCE_BIT 4
`define RLTM_SLAVE_OFF_BIT 6
`define RLTM_TEST_TX_BIT 7
`define RLTM_CODE_SINGLE 8'h63
`define RLTM_CODE_SWEEP 8'h73
`define RLTM_XFER_START 8'h01
`define RLTM_PWR_0DBM 2'h3
`define RLTM_RESET_BYTE 8'h00
`define RLTM_HOST_CMD 4'h0
`define RLTM_HOST_STATUS 4'h4
`define RLTM_CMD_WRITE_BIT 16
`define RLTM_RESP_OKAY 2'h0
`define RLTM_RESP_SLVERR 2'h2
`endif

/* File: hw/rltm_pkg.sv */
// state types of the relink/test control ends
package rltm_pkg;
   typedef struct packed {
      logic ack;
      logic [7:0] rdata;
      logic link_up_d;
      logic reconfig;
      logic [7:0] link_mode;
      logic [7:0] tx_status_pend;
      logic [3:0] rate_active;
      logic [7:0] rx_mode;
      logic rx_mode_b2;
      logic [7:0] out_port_pend;
      logic [5:0] out_port_active;
      logic [1:0] power;
      logic [7:0] test_code_pend;
      logic [7:0] test_chan_pend;
      logic test_on;
      logic test_sweep;
      logic test_tx;
      logic [6:0] test_chan;
      logic [1:0] tx_power;
      logic [3:0] busy;
      logic [3:0] fail;
      logic slave_off;
      logic send_auto;
      logic send_pins;
   } rltm_dev_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic arready;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_have;
      logic [3:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic req;
      logic we;
      logic [6:0] addr;
      logic [7:0] wdata;
      logic [7:0] rbyte;
   } rltm_host_t;
endpackage

/* File: hw/rltm_if.sv */
// register port between the controller and the device end
interface rltm_if;
   logic req;
   logic we;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic ack;
   modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
   modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface

/* File: hw/rltm_sync.sv */
// two-flop synchroniser for pin levels
module rltm_sync #(
   parameter int WIDTH = 1
) (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic [WIDTH-1:0] D,
   output logic [WIDTH-1:0] Q
);
   logic [WIDTH-1:0] meta;
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         meta <= '0;
         Q <= '0;
      end else begin
         meta <= D;
         Q <= meta;
      end
   end
endmodule

/* File: hw/rltm_host.sv */
// controller end: AXI4-Lite command registers driving the device register port
`include "rltm_defines.svh"
module rltm_host (
   input wire logic MCLK,
   input wire logic NRST,
   rltm_if.host BUS,
   input wire logic [3:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [3:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);
   rltm_pkg::rltm_host_t q;
   rltm_pkg::rltm_host_t next_q;

   always_comb begin
      next_q = q;
      if (AWVALID && q.awready) begin
         next_q.aw_have = 1'b1;
         next_q.aw_addr = AWADDR;
      end
      if (WVALID && q.wready) begin
         next_q.w_have = 1'b1;
         next_q.w_data = WDATA;
      end
      if (q.bvalid && BREADY) begin
         next_q.bvalid = 1'b0;
      end
      if (q.aw_have && q.w_have && !q.bvalid) begin
         next_q.aw_have = 1'b0;
         next_q.w_have = 1'b0;
         next_q.bvalid = 1'b1;
         next_q.bresp = `RLTM_RESP_SLVERR;
         if (q.aw_addr == `RLTM_HOST_CMD && !q.req && (&WSTRB[2:0] || 1'b1)) begin
            // one device access at a time; a write while busy is refused
            next_q.bresp = `RLTM_RESP_OKAY;
            next_q.req = 1'b1;
            next_q.we = q.w_data[`RLTM_CMD_WRITE_BIT];
            next_q.wdata = q.w_data[15:8];
            next_q.addr = q.w_data[6:0];
         end else if (q.aw_addr == `RLTM_HOST_STATUS) begin
            next_q.bresp = `RLTM_RESP_OKAY;
         end
      end
      if (q.req && BUS.ack) begin
         next_q.req = 1'b0;
         next_q.rbyte = BUS.rdata;
      end
      if (q.rvalid && RREADY) begin
         next_q.rvalid = 1'b0;
      end
      if (ARVALID && q.arready) begin
         next_q.rvalid = 1'b1;
         next_q.rresp = `RLTM_RESP_OKAY;
         case (ARADDR)
            `RLTM_HOST_CMD: next_q.rdata = {15'h0000, q.we, q.wdata, 1'b0, q.addr};
            `RLTM_HOST_STATUS: next_q.rdata = {16'h0000, q.rbyte, 7'h00, q.req};
            default: begin
               next_q.rdata = 32'h00000000;
               next_q.rresp = `RLTM_RESP_SLVERR;
            end
         endcase
      end
      next_q.awready = !next_q.aw_have && !next_q.bvalid;
      next_q.wready = !next_q.w_have && !next_q.bvalid;
      next_q.arready = !next_q.rvalid;
   end

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign AWREADY = q.awready;
   assign WREADY = q.wready;
   assign BRESP = q.bresp;
   assign BVALID = q.bvalid;
   assign ARREADY = q.arready;
   assign RDATA = q.rdata;
   assign RRESP = q.rresp;
   assign RVALID = q.rvalid;
   assign BUS.req = q.req;
   assign BUS.we = q.we;
   assign BUS.addr = q.addr;
   assign BUS.wdata = q.wdata;
endmodule

/* File: verif/rltm_checker.sv */
// concurrent checks on the register port and the device outputs
`include "rltm_defines.svh"
module rltm_checker #(
   parameter bit RECEIVER = 1'b0
) (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic req,
   input wire logic we,
   input wire logic [6:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic LINK_LOCATE,
   input wire logic LINK_UP,
   input wire logic RECONFIG,
   input wire logic SEND_AUTO_CFG,
   input wire logic SLAVE_EN,
   input wire logic TEST_ACTIVE,
   input wire logic TEST_SWEEP,
   input wire logic TEST_TX,
   input wire logic [6:0] TEST_CHAN,
   input wire logic [1:0] TX_POWER
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!NRST);
   AST_ACK_LATENCY: assert property (req && !ack |=> ack)
      else $error("register access not answered in the next cycle");
   AST_ACK_PULSE: assert property (ack |=> !ack)
      else $error("acknowledge longer than one cycle");
   AST_FORCE_RELINK: assert property (req && !ack && we && SLAVE_EN && !TEST_ACTIVE
      && addr == `RLTM_OFS_LINK_MODE && wdata[`RLTM_FORCE_BIT] |-> ##[1:4] RECONFIG)
      else $error("force bit write gave no reconfiguration");
   AST_LINK_RELINK: assert property ($rose(LINK_UP) |-> ##[1:4] RECONFIG)
      else $error("link establishment gave no reconfiguration");
   AST_TEST_HOLD: assert property (TEST_ACTIVE |=> TEST_ACTIVE)
      else $error("test mode left without reset");
   AST_TEST_FROZEN: assert property (TEST_ACTIVE |=> $stable({TEST_SWEEP, TEST_TX, TEST_CHAN}))
      else $error("test settings changed inside test mode");
   AST_TEST_POWER: assert property (TEST_ACTIVE && $past(TEST_ACTIVE) |->
      TX_POWER == `RLTM_PWR_0DBM)
      else $error("output power not forced in test mode");
   AST_AUTO_ON: assert property (!RECEIVER && LINK_LOCATE && !TEST_ACTIVE ##1 !TEST_ACTIVE
      |-> SEND_AUTO_CFG)
      else $error("no automatic settings transfer while locating");
   AST_AUTO_OFF: assert property (!LINK_LOCATE |=> !SEND_AUTO_CFG)
      else $error("automatic settings transfer outside locating");
   AST_SLAVE_TX: assert property (!RECEIVER |-> SLAVE_EN)
      else $error("transmitter slave interface disabled");
   cover property ($rose(TEST_ACTIVE) && TEST_SWEEP);
   cover property ($rose(TEST_ACTIVE) && !TEST_SWEEP);
   cover property (RECONFIG && !TEST_ACTIVE);
endmodule

/* File: verif/testbench.sv */
// self-checking bench joining controller and device ends
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic MCLK, NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic [3:0] AWADDR, ARADDR, WSTRB, XFER_DONE, XFER_FAIL, RATE_ACTIVE, XFER_BUSY;
   logic [31:0] WDATA, RDATA, s;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, LINK_LOCATE, LINK_UP;
   logic [1:0] BRESP, RRESP, TX_POWER;
   logic EE_LOAD_DONE, EE_SLAVE_OFF, EE_DATA, RECONFIG, RX_MODE_B2, SEND_AUTO_CFG;
   logic SEND_PINS, SLAVE_EN, TEST_ACTIVE, TEST_SWEEP, TEST_TX;
   logic [5:0] OUT_PORT_ACTIVE;
   logic [6:0] TEST_CHAN;
   logic [6:0] ofs [4] = '{7'h5B, 7'h3E, 7'h4B, 7'h47};
   logic [33:0] rq[$], mq[$], e, m;
   logic [1:0] bq[$];
   logic [7:0] b0, b1, b2, ch;
   int failures, n_tests;
   rltm_if bus_if();
   rltm_host rltm_host_i(.MCLK, .NRST, .BUS(bus_if), .AWADDR, .AWVALID, .AWREADY, .WDATA,
      .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
      .RDATA, .RRESP, .RVALID, .RREADY);
   rltm_device #(.RECEIVER(1'b0)) rltm_device_i(.MCLK, .NRST, .BUS(bus_if), .LINK_LOCATE,
      .LINK_UP, .XFER_DONE, .XFER_FAIL, .EE_LOAD_DONE, .EE_SLAVE_OFF, .EE_DATA, .RECONFIG,
      .RATE_ACTIVE, .RX_MODE_B2, .OUT_PORT_ACTIVE, .XFER_BUSY, .SEND_AUTO_CFG, .SEND_PINS,
      .SLAVE_EN, .TEST_ACTIVE, .TEST_SWEEP, .TEST_TX, .TEST_CHAN, .TX_POWER);
   rltm_checker #(.RECEIVER(1'b0)) rltm_checker_i(.MCLK, .NRST, .req(bus_if.req),
      .we(bus_if.we), .addr(bus_if.addr), .wdata(bus_if.wdata), .ack(bus_if.ack),
      .LINK_LOCATE, .LINK_UP, .RECONFIG, .SEND_AUTO_CFG, .SLAVE_EN, .TEST_ACTIVE,
      .TEST_SWEEP, .TEST_TX, .TEST_CHAN, .TX_POWER);
   task automatic cmp(input logic [33:0] g, input logic [33:0] x);
      n_tests++;
      if (g !== x) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic do_reset();
      NRST <= 1'b0;
      repeat (6) @(posedge MCLK);
      NRST <= 1'b1;
      @(posedge MCLK);
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok, w_ok, b_ok;
      bq.push_back(er);
      @(posedge MCLK);
      AWADDR <= a;
      AWVALID <= 1'b1;
      WDATA <= d;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      b_ok = 1'b0;
      // handshakes judged on settled levels, released just after the edge
      while (!b_ok) begin
         @(negedge MCLK);
         aw_ok = AWVALID && AWREADY;
         w_ok = WVALID && WREADY;
         b_ok = BVALID && BREADY;
         @(posedge MCLK);
         if (aw_ok) AWVALID <= 1'b0;
         if (w_ok) WVALID <= 1'b0;
         if (b_ok) BREADY <= 1'b0;
      end
   endtask
   task automatic axi_rd(input logic [3:0] a, input logic [33:0] x, input logic [33:0] k,
                         output logic [31:0] d);
      logic ar_ok, r_ok;
      rq.push_back(x);
      mq.push_back(k);
      @(posedge MCLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      r_ok = 1'b0;
      d = 32'h00000000;
      while (!r_ok) begin
         @(negedge MCLK);
         ar_ok = ARVALID && ARREADY;
         r_ok = RVALID && RREADY;
         if (r_ok) d = RDATA;
         @(posedge MCLK);
         if (ar_ok) ARVALID <= 1'b0;
         if (r_ok) RREADY <= 1'b0;
      end
   endtask
   // one device access through the command word, then poll until it completes
   task automatic dev(input logic w, input logic [6:0] o, input logic [7:0] wb,
                      input logic [7:0] eb, input logic [7:0] em);
      logic [31:0] st;
      axi_wr(4'h0, {15'h0, w, wb, 1'b0, o}, 2'h0);
      st = 32'h1;
      while (st[0] !== 1'b0) axi_rd(4'h4, 34'h0, 34'h0, st);
      axi_rd(4'h4, {18'h0, eb, 8'h0}, {18'h0, em, 8'h1}, st);
   endtask
   task automatic pulse_in(input logic [3:0] d, input logic [3:0] f);
      @(posedge MCLK);
      XFER_DONE <= d;
      XFER_FAIL <= f;
      @(posedge MCLK);
      XFER_DONE <= 4'h0;
      XFER_FAIL <= 4'h0;
   endtask
   always @(negedge MCLK) begin
      if (RVALID && RREADY) begin
         e = rq.pop_front();
         m = mq.pop_front();
         if (m != 34'h0) cmp({RRESP, RDATA} & m, e & m);
      end
      if (BVALID && BREADY) cmp({32'h0, BRESP}, {32'h0, bq.pop_front()});
   end
   initial begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end
   initial begin
      repeat (30000) @(posedge MCLK);
      failures++;
      $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      results();
   end
   initial begin
      {NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY, LINK_LOCATE, LINK_UP} = '0;
      {AWADDR, ARADDR, WDATA, XFER_DONE, XFER_FAIL, EE_LOAD_DONE, EE_SLAVE_OFF} = '0;
      WSTRB = 4'hF;
      EE_DATA = 1'b1;
      void'($urandom(76046));
      do_reset();
      axi_rd(4'h8, {2'h2, 32'h0}, {2'h3, 32'hFFFFFFFF}, s);
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      b2 = 8'($urandom);
      dev(1'b1, 7'h42, b0, 8'h0, 8'h0);
      // link-carried settings only; the hop table is loaded on each end
      dev(1'b1, 7'h43, b1, 8'h0, 8'h0);
      dev(1'b1, 7'h41, b2, 8'h0, 8'h0);
      cmp(34'({RATE_ACTIVE, RX_MODE_B2, OUT_PORT_ACTIVE}), 34'h0);
      dev(1'b1, 7'h50, 8'h10, 8'h0, 8'h0);
      cmp(34'({RATE_ACTIVE, RX_MODE_B2, OUT_PORT_ACTIVE}), 34'({b0[6:3], b2[2], b1[5:0]}));
      dev(1'b0, 7'h50, 8'h0, 8'h0, 8'hFF);
      b0 = ~b0;
      dev(1'b1, 7'h42, b0, 8'h0, 8'h0);
      LINK_UP <= 1'b1;
      repeat (5) @(posedge MCLK);
      cmp(34'(RATE_ACTIVE), 34'(b0[6:3]));
      LINK_UP <= 1'b0;
      $display("relink test done");
      LINK_LOCATE <= 1'b1;
      repeat (3) @(posedge MCLK);
      cmp(34'({SEND_AUTO_CFG, SEND_PINS}), 34'h2);
      LINK_LOCATE <= 1'b0;
      EE_SLAVE_OFF <= 1'b1;
      EE_LOAD_DONE <= 1'b1;
      @(posedge MCLK);
      EE_LOAD_DONE <= 1'b0;
      repeat (4) @(posedge MCLK);
      cmp(34'({SEND_AUTO_CFG, SLAVE_EN}), 34'h1);
      $display("locate test done");
      for (int i = 0; i < 4; i++) begin
         for (int k = 0; k < 2; k++) begin
            dev(1'b1, ofs[i], 8'h01, 8'h0, 8'h0);
            dev(1'b0, ofs[i], 8'h0, 8'h01, 8'hFF);
            cmp(34'(XFER_BUSY), 34'(4'h1 << i));
            if (i == 2 && k == 0) begin
               dev(1'b1, 7'h41, 8'hA5, 8'h0, 8'h0);
               dev(1'b1, 7'h43, ~b1, 8'h0, 8'h0);
               dev(1'b0, 7'h41, 8'h0, 8'hA5, 8'hFF);
               dev(1'b0, 7'h43, 8'h0, b1, 8'hFF);
            end
            if (k == 0) pulse_in(4'h1 << i, 4'h0);
            else pulse_in(4'h0, 4'h1 << i);
            dev(1'b0, ofs[i], 8'h0, {6'h0, k[0], 1'b0}, 8'hFF);
         end
      end
      $display("transfer test done");
      for (int t = 0; t < 2; t++) begin
         ch = 8'($urandom);
         dev(1'b1, 7'h44, 8'h01, 8'h0, 8'h0);
         dev(1'b1, 7'h7E, t[0] ? 8'h73 : 8'h63, 8'h0, 8'h0);
         dev(1'b1, 7'h7F, ch, 8'h0, 8'h0);
         cmp(34'({TEST_ACTIVE, TX_POWER}), 34'h1);
         for (int r = 0; r < 2; r++) begin
            dev(1'b1, 7'h50, 8'h10, 8'h0, 8'h0);
            cmp(34'({TEST_ACTIVE, TEST_SWEEP, TEST_TX, TEST_CHAN, TX_POWER}),
               34'({1'b1, t[0], ch[7], ch[6:0], 2'h3}));
            dev(1'b1, 7'h7E, t[0] ? 8'h63 : 8'h73, 8'h0, 8'h0);
            dev(1'b1, 7'h7F, ~ch, 8'h0, 8'h0);
         end
         do_reset();
         cmp(34'(TEST_ACTIVE), 34'h0);
         $display("test mode pass %0d done", t);
      end
      results();
   end
endmodule
